// [swcs_pkg.sv]
// setup word layout, clock kinds, timing constants and shared decoders
package swcs_pkg;
    localparam logic [13:0] SETUP_ADDR = 14'h2007;
    localparam logic [13:0] CFG_LO_ADDR = 14'h2000;
    localparam logic [13:0] CFG_HI_ADDR = 14'h3fff;
    localparam logic [13:0] TRIM_ADDR = 14'h03ff;
    localparam logic [13:0] SETUP_RST = 14'h31ff;
    localparam logic [13:0] UNIMPL_MASK = 14'h0e00;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    localparam logic [13:0] RETURN_LITERAL_OP_OP = 14'h3400;
    localparam logic [13:0] RETURN_LITERAL_OP_MASK = 14'h3f00;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam int BG_HI_BIT = 13;
    localparam int BG_LO_BIT = 12;
    localparam int DLOCK_BIT = 8;
    localparam int CLOCK_BIT = 7;
    localparam int BOD_BIT = 6;
    localparam int MASTER_RESET_PIN_BIT = 5;
    localparam int POWERUP_DELAY_TIMER_BIT = 4;
    localparam int WDT_BIT = 3;
    localparam int KIND_HI_BIT = 2;
    localparam logic [2:0] KIND_LP = 3'h0;
    localparam logic [2:0] KIND_XT = 3'h1;
    localparam logic [2:0] KIND_HS = 3'h2;
    localparam logic [2:0] KIND_EC = 3'h3;
    localparam logic [2:0] KIND_INT_IO = 3'h4;
    localparam logic [2:0] KIND_INT_QUARTER_CLOCK_OUTPUT = 3'h5;
    localparam logic [2:0] KIND_RC_IO = 3'h6;
    localparam logic [2:0] KIND_RC_QUARTER_CLOCK_OUTPUT = 3'h7;
    localparam int CLK_HZ = 10_000_000;
    localparam int POWERUP_DELAY_TIMER_MS = 72;
    localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
    localparam int POWERUP_DELAY_TIMER_W = 20;
    localparam int OST_CYC = 1024;
    localparam int OST_W = 11;

    typedef enum logic [1:0] {PH_LOAD, PH_POWERUP_DELAY_TIMER, PH_OST, PH_RUN} swcs_phase_t;

    function automatic logic is_crystal(input logic [2:0] k);
        return k <= KIND_HS;
    endfunction
    function automatic logic out_is_io(input logic [2:0] k);
        return (k == KIND_EC) || (k == KIND_INT_IO) || (k == KIND_RC_IO);
    endfunction
    function automatic logic in_is_io(input logic [2:0] k);
        return (k == KIND_INT_IO) || (k == KIND_INT_QUARTER_CLOCK_OUTPUT);
    endfunction
    function automatic logic has_quarter_clock_output(input logic [2:0] k);
        return (k == KIND_INT_QUARTER_CLOCK_OUTPUT) || (k == KIND_RC_QUARTER_CLOCK_OUTPUT);
    endfunction
    function automatic logic rc_or_int(input logic [2:0] k);
        return k >= KIND_INT_IO;
    endfunction
endpackage

// [swcs_sync.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module swcs_sync
    import swcs_pkg::*;
#(
    parameter int W = 1
)(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stage;
    } swcs_sync_t;

    swcs_sync_t s_r;
    swcs_sync_t s_nxt;

    always_comb
    begin
        s_nxt.meta = i_async;
        s_nxt.stage = s_r.meta;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_sync = s_r.stage;
endmodule
`default_nettype wire

// [swcs_timer.sv]
// loadable down counter for the start-up delays
`timescale 1ns/10ps
`default_nettype none
module swcs_timer
    import swcs_pkg::*;
#(
    parameter int W = 8
)(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_load,
    input wire logic i_count,
    input wire logic [W-1:0] i_value,
    output logic o_done
);
    typedef struct packed {
        logic [W-1:0] count;
    } swcs_timer_t;

    swcs_timer_t s_r;
    swcs_timer_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (i_load)
            s_nxt.count = i_value;
        else if (i_count && (s_r.count != '0))
            s_nxt.count = s_r.count - 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_done = (s_r.count == '0);
endmodule
`default_nettype wire

// [swcs_setup_word.sv]
// setup word store, decode, start-up sequencing and clock pin control
`timescale 1ns/10ps
`default_nettype none
module swcs_setup_word
    import swcs_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC,
    parameter int OST_CYCLES = OST_CYC,
    parameter logic [13:0] INIT_WORD = SETUP_RST,
    parameter logic [13:0] INIT_TRIM_WORD = ERASED_WORD
)(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_prog_mode,
    input wire logic [13:0] i_prog_addr,
    input wire logic [13:0] i_prog_wdata,
    input wire logic i_prog_write,
    input wire logic i_prog_erase,
    output logic [13:0] o_prog_rdata,
    output logic o_erase_data,
    output logic o_erase_program,
    input wire logic i_master_reset_pin_n,
    input wire logic i_clock_in_pin,
    input wire logic i_brownout,
    input wire logic i_wake,
    input wire logic i_trim_write,
    input wire logic [7:0] i_trim_wdata,
    output logic [7:0] o_oscillator_trim_reg,
    output logic [7:0] o_trim_literal,
    output logic o_trim_literal_ok,
    input wire logic i_port_a_bit4_out,
    input wire logic i_port_a_bit4_oe,
    output logic o_clock_out_pin_o,
    output logic o_clock_out_pin_oe,
    output logic o_clock_in_pin_is_io,
    output logic o_clock_out_pin_is_io,
    output logic o_resonator_on,
    output logic o_driven_clock_in,
    output logic [2:0] o_clock_kind_field,
    output logic o_osc_run,
    output logic o_port_a_bit3_is_io,
    output logic [1:0] o_bandgap_trim_pair,
    output logic o_data_protect,
    output logic o_code_protect,
    output logic o_undervoltage_guard_on,
    output logic o_powerup_delay_on,
    output logic o_watchdog_on,
    output logic o_core_reset
);
    typedef struct packed {
        swcs_phase_t phase;
        logic [13:0] word;
        logic [13:0] latch;
        logic [13:0] trim_word;
        logic [7:0] trim;
        logic [13:0] rdata;
        logic [1:0] div;
        logic ck_prev;
        logic pin_o;
        logic pin_oe;
        logic erase_data;
        logic erase_prog;
    } swcs_state_t;

    swcs_state_t s_r;
    swcs_state_t s_nxt;
    logic [2:0] pins_s;
    logic master_reset_pin_n_s;
    logic ck_s;
    logic bo_s;
    logic osc_edge;
    logic master_reset_pin_act;
    logic [2:0] kind;
    logic powerup_delay_timer_load;
    logic ost_load;
    logic powerup_delay_timer_done;
    logic ost_done;

    swcs_sync #(.W(3)) u_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        // pin sampled inverted so the flops' reset level means "reset pin idle"
        .i_async({!i_master_reset_pin_n, i_clock_in_pin, i_brownout}),
        .o_sync(pins_s)
    );

    assign master_reset_pin_n_s = !pins_s[2];
    assign ck_s = pins_s[1];
    assign bo_s = pins_s[0];
    // only slow crystals are resolvable at this sample rate
    assign osc_edge = ck_s && !s_r.ck_prev;
    assign kind = s_r.latch[KIND_HI_BIT:0];
    assign master_reset_pin_act = s_r.latch[MASTER_RESET_PIN_BIT] && !master_reset_pin_n_s;

    assign powerup_delay_timer_load = (s_nxt.phase == PH_POWERUP_DELAY_TIMER) && (s_r.phase != PH_POWERUP_DELAY_TIMER);
    assign ost_load = (s_nxt.phase == PH_OST) && (s_r.phase != PH_OST);

    swcs_timer #(.W(POWERUP_DELAY_TIMER_W)) u_powerup_delay_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_load(powerup_delay_timer_load),
        .i_count(s_r.phase == PH_POWERUP_DELAY_TIMER),
        .i_value(POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1)),
        .o_done(powerup_delay_timer_done)
    );

    swcs_timer #(.W(OST_W)) u_ost (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_load(ost_load),
        .i_count((s_r.phase == PH_OST) && osc_edge),
        .i_value(OST_W'(OST_CYCLES - 1)),
        .o_done(ost_done)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.erase_data = 1'b0;
        s_nxt.erase_prog = 1'b0;
        s_nxt.rdata = '0;
        s_nxt.ck_prev = ck_s;
        s_nxt.div = s_r.div + 2'h1;
        if (i_trim_write)
            s_nxt.trim = i_trim_wdata;
        // the setup region answers only in programming mode
        if (i_prog_mode)
        begin
            if (i_prog_erase)
            begin
                // bulk erase loses both trims; restoring them is the programmer's job
                s_nxt.word = SETUP_RST;
                s_nxt.trim_word = ERASED_WORD;
                s_nxt.erase_data = 1'b1;
                s_nxt.erase_prog = 1'b1;
            end
            else if (i_prog_write && (i_prog_addr == SETUP_ADDR))
            begin
                s_nxt.word = i_prog_wdata & ~UNIMPL_MASK;
                if (!s_r.word[DLOCK_BIT] && i_prog_wdata[DLOCK_BIT])
                    s_nxt.erase_data = 1'b1;
                if (!s_r.word[CLOCK_BIT] && i_prog_wdata[CLOCK_BIT])
                begin
                    s_nxt.erase_prog = 1'b1;
                    s_nxt.trim_word = ERASED_WORD;
                end
            end
            else if (i_prog_write && (i_prog_addr == TRIM_ADDR))
                s_nxt.trim_word = i_prog_wdata;
            else if (!i_prog_write)
            begin
                if (i_prog_addr == SETUP_ADDR)
                    s_nxt.rdata = s_r.word & ~UNIMPL_MASK;
                else if ((i_prog_addr == TRIM_ADDR) && s_r.word[CLOCK_BIT])
                    s_nxt.rdata = s_r.trim_word;
            end
        end
        case (s_r.phase)
            PH_LOAD:
            begin
                s_nxt.latch = s_r.word;
                if (!s_r.word[POWERUP_DELAY_TIMER_BIT])
                    s_nxt.phase = PH_POWERUP_DELAY_TIMER;
                else if (is_crystal(s_r.word[KIND_HI_BIT:0]))
                    s_nxt.phase = PH_OST;
                else
                    s_nxt.phase = PH_RUN;
            end
            PH_POWERUP_DELAY_TIMER:
            begin
                if (powerup_delay_timer_done)
                    s_nxt.phase = is_crystal(kind) ? PH_OST : PH_RUN;
            end
            PH_OST:
            begin
                if (ost_done)
                    s_nxt.phase = PH_RUN;
            end
            PH_RUN:
            begin
                if (i_wake && is_crystal(kind))
                    s_nxt.phase = PH_OST;
            end
            default:
                s_nxt.phase = PH_LOAD;
        endcase
        // brown-out restarts the whole sequence; the delay itself still obeys its own bit
        if (i_prog_mode || (s_r.latch[BOD_BIT] && bo_s))
            s_nxt.phase = PH_LOAD;
        if (has_quarter_clock_output(kind))
        begin
            s_nxt.pin_o = s_nxt.div[1];
            s_nxt.pin_oe = 1'b1;
        end
        else
        begin
            s_nxt.pin_o = i_port_a_bit4_out;
            s_nxt.pin_oe = out_is_io(kind) && i_port_a_bit4_oe;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            s_r.phase <= PH_LOAD;
            s_r.word <= INIT_WORD;
            s_r.latch <= SETUP_RST;
            s_r.trim_word <= INIT_TRIM_WORD;
            s_r.trim <= TRIM_RST;
            s_r.rdata <= '0;
            s_r.div <= '0;
            s_r.ck_prev <= 1'b0;
            s_r.pin_o <= 1'b0;
            s_r.pin_oe <= 1'b0;
            s_r.erase_data <= 1'b0;
            s_r.erase_prog <= 1'b0;
        end
        else
            s_r <= s_nxt;
    end

    assign o_prog_rdata = s_r.rdata;
    assign o_erase_data = s_r.erase_data;
    assign o_erase_program = s_r.erase_prog;
    assign o_oscillator_trim_reg = s_r.trim;
    assign o_trim_literal = s_r.trim_word[7:0];
    assign o_trim_literal_ok = (s_r.trim_word & RETURN_LITERAL_OP_MASK) == RETURN_LITERAL_OP_OP;
    assign o_clock_out_pin_o = s_r.pin_o;
    assign o_clock_out_pin_oe = s_r.pin_oe;
    assign o_clock_in_pin_is_io = in_is_io(kind);
    assign o_clock_out_pin_is_io = out_is_io(kind);
    assign o_resonator_on = is_crystal(kind);
    assign o_driven_clock_in = (kind == KIND_EC);
    assign o_clock_kind_field = kind;
    // a held master reset parks the self-timed oscillators
    assign o_osc_run = !(master_reset_pin_act && rc_or_int(kind));
    assign o_port_a_bit3_is_io = !s_r.latch[MASTER_RESET_PIN_BIT];
    assign o_bandgap_trim_pair = s_r.latch[BG_HI_BIT:BG_LO_BIT];
    assign o_data_protect = !s_r.latch[DLOCK_BIT];
    assign o_code_protect = !s_r.latch[CLOCK_BIT];
    assign o_undervoltage_guard_on = s_r.latch[BOD_BIT];
    assign o_powerup_delay_on = !s_r.latch[POWERUP_DELAY_TIMER_BIT];
    assign o_watchdog_on = s_r.latch[WDT_BIT];
    assign o_core_reset = (s_r.phase != PH_RUN) || master_reset_pin_act;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    sequence s_setup_write;
        i_prog_mode && !i_prog_erase && i_prog_write && (i_prog_addr == SETUP_ADDR);
    endsequence
    sequence s_powerup_delay_timer_enter;
        (s_r.phase == PH_LOAD) && !i_prog_mode && !s_r.word[POWERUP_DELAY_TIMER_BIT]
            && !(s_r.latch[BOD_BIT] && bo_s);
    endsequence

    property p_latch_sample;
        (s_r.phase == PH_LOAD) |=> (s_r.latch == $past(s_r.word));
    endproperty
    a_latch_sample: assert property (p_latch_sample) else $error("latch missed word");

    property p_latch_hold;
        (s_r.phase == PH_RUN) && ($past(s_r.phase) == PH_RUN) |-> $stable(s_r.latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved in run");

    property p_unimpl;
        i_prog_mode && (i_prog_addr == SETUP_ADDR) |=> ((o_prog_rdata & UNIMPL_MASK) == '0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read set");

    property p_no_run_read;
        !i_prog_mode |=> (o_prog_rdata == '0);
    endproperty
    a_no_run_read: assert property (p_no_run_read) else $error("read outside programming");

    property p_setup_read;
        i_prog_mode && !i_prog_erase && !i_prog_write && (i_prog_addr == SETUP_ADDR)
            |=> (o_prog_rdata == ($past(s_r.word) & ~UNIMPL_MASK));
    endproperty
    a_setup_read: assert property (p_setup_read) else $error("setup read wrong");

    property p_erase_data;
        s_setup_write ##0 (!s_r.word[DLOCK_BIT] && i_prog_wdata[DLOCK_BIT]) |=> o_erase_data;
    endproperty
    a_erase_data: assert property (p_erase_data) else $error("data erase missing");

    property p_erase_prog;
        s_setup_write ##0 (!s_r.word[CLOCK_BIT] && i_prog_wdata[CLOCK_BIT])
            |=> o_erase_program && (s_r.trim_word == ERASED_WORD);
    endproperty
    a_erase_prog: assert property (p_erase_prog) else $error("program erase missing");

    property p_master_reset_pin_osc;
        master_reset_pin_act && rc_or_int(kind) |-> !o_osc_run;
    endproperty
    a_master_reset_pin_osc: assert property (p_master_reset_pin_osc) else $error("oscillator ran in reset");

    property p_master_reset_pin_off;
        !s_r.latch[MASTER_RESET_PIN_BIT] |-> !master_reset_pin_act && o_port_a_bit3_is_io;
    endproperty
    a_master_reset_pin_off: assert property (p_master_reset_pin_off) else $error("reset pin acted when off");

    property p_quarter;
        has_quarter_clock_output(kind) && $past(has_quarter_clock_output(kind), 3) && $stable(kind)
            && !$past(i_reset) && !$past(i_reset, 2)
            |-> (o_clock_out_pin_o != $past(o_clock_out_pin_o, 2)) && o_clock_out_pin_oe;
    endproperty
    a_quarter: assert property (p_quarter) else $error("quarter clock wrong");

    property p_powerup_delay_timer_skip;
        (s_r.phase == PH_LOAD) && !i_prog_mode && s_r.word[POWERUP_DELAY_TIMER_BIT]
            && !is_crystal(s_r.word[KIND_HI_BIT:0]) && !(s_r.latch[BOD_BIT] && bo_s)
            |=> (s_r.phase == PH_RUN);
    endproperty
    a_powerup_delay_timer_skip: assert property (p_powerup_delay_timer_skip) else $error("delay ran while off");

    property p_powerup_delay_timer_hold;
        s_powerup_delay_timer_enter |=> (s_r.phase == PH_POWERUP_DELAY_TIMER) ##1 o_core_reset;
    endproperty
    a_powerup_delay_timer_hold: assert property (p_powerup_delay_timer_hold) else $error("delay not held");

    property p_ost_crystal;
        (s_r.phase == PH_OST) |-> is_crystal(kind) && o_core_reset;
    endproperty
    a_ost_crystal: assert property (p_ost_crystal) else $error("settle outside crystal");

    property p_brownout;
        s_r.latch[BOD_BIT] && bo_s |=> (s_r.phase == PH_LOAD);
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out ignored");
endmodule
`default_nettype wire

// [swcs_partner.sv]
// programmer and clock source on the far side of the setup word block
`timescale 1ns/10ps
`default_nettype none
module swcs_partner
    import swcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_osc_run,
    input wire logic [13:0] i_prog_rdata,
    output logic o_clock_in_pin,
    output logic o_prog_mode,
    output logic [13:0] o_prog_addr,
    output logic [13:0] o_prog_wdata,
    output logic o_prog_write,
    output logic o_prog_erase
);
    logic [1:0] div_r;

    initial
    begin
        div_r = 2'h0;
        o_clock_in_pin = 1'b0;
        o_prog_mode = 1'b0;
        o_prog_addr = 14'h0000;
        o_prog_wdata = 14'h0000;
        o_prog_write = 1'b0;
        o_prog_erase = 1'b0;
    end

    // source stands low between frames, period of six core clocks
    always @(posedge i_clock)
    begin
        if (!i_osc_run)
        begin
            div_r <= 2'h0;
            o_clock_in_pin <= 1'b0;
        end
        else if (div_r == 2'h2)
        begin
            div_r <= 2'h0;
            o_clock_in_pin <= ~o_clock_in_pin;
        end
        else
            div_r <= div_r + 2'h1;
    end

    task automatic put(input logic [13:0] a, input logic [13:0] d, input logic w,
        input logic e);
        @(posedge i_clock);
        o_prog_mode <= 1'b1;
        o_prog_addr <= a;
        o_prog_wdata <= d;
        o_prog_write <= w;
        o_prog_erase <= e;
        @(posedge i_clock);
        o_prog_write <= 1'b0;
        o_prog_erase <= 1'b0;
        o_prog_wdata <= ~d;
    endtask

    task automatic get(input logic [13:0] a, output logic [13:0] d);
        put(a, 14'h0000, 1'b0, 1'b0);
        #1;
        d = i_prog_rdata;
    endtask

    task automatic leave;
        @(posedge i_clock);
        o_prog_mode <= 1'b0;
    endtask

    // calibration survives a bulk erase only if saved first
    task automatic erase_keep;
        logic [13:0] w;
        logic [13:0] t;
        get(SETUP_ADDR, w);
        get(TRIM_ADDR, t);
        put(14'h0000, 14'h0000, 1'b0, 1'b1);
        put(SETUP_ADDR, {w[13:12], 12'hfff}, 1'b1, 1'b0);
        put(TRIM_ADDR, t, 1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// [tb_setup_word_clock_select.sv]
// self-checking bench for the setup word and clock pin block
`timescale 1ns/10ps
`default_nettype none
module tb_setup_word_clock_select;
    import swcs_pkg::*;
    localparam int PW = 8;
    localparam int OS = 4;
    logic clk, rst, pin_n, brown, wake, trim_wr, b4_out, b4_oe, src_run;
    logic mode, wr, er, cin, e_data, e_prog, co_o, co_oe, ci_io, co_io;
    logic reson, drv, osc_run, p3_io, dprot, cprot, guard, dly, wdog, core_rst;
    logic lit_ok, pv;
    logic [7:0] trim_d, trim_reg, lit;
    logic [13:0] rdata, addr, wdata, w, v, dec;
    logic [2:0] kind;
    logic [1:0] bg;
    int n_mismatch, comparisons, n;

    assign dec = {bg, dprot, cprot, guard, dly, wdog, kind, ci_io, co_io, reson, drv};

    swcs_partner partner_u (.i_clock(clk), .i_osc_run(src_run), .i_prog_rdata(rdata),
        .o_clock_in_pin(cin), .o_prog_mode(mode), .o_prog_addr(addr),
        .o_prog_wdata(wdata), .o_prog_write(wr), .o_prog_erase(er));

    swcs_setup_word #(.POWERUP_DELAY_TIMER_CYCLES(PW), .OST_CYCLES(OS)) dut_u (
        .i_clock(clk), .i_reset(rst), .i_prog_mode(mode), .i_prog_addr(addr),
        .i_prog_wdata(wdata), .i_prog_write(wr), .i_prog_erase(er),
        .o_prog_rdata(rdata), .o_erase_data(e_data), .o_erase_program(e_prog),
        .i_master_reset_pin_n(pin_n), .i_clock_in_pin(cin), .i_brownout(brown),
        .i_wake(wake), .i_trim_write(trim_wr), .i_trim_wdata(trim_d),
        .o_oscillator_trim_reg(trim_reg), .o_trim_literal(lit),
        .o_trim_literal_ok(lit_ok), .i_port_a_bit4_out(b4_out),
        .i_port_a_bit4_oe(b4_oe), .o_clock_out_pin_o(co_o), .o_clock_out_pin_oe(co_oe),
        .o_clock_in_pin_is_io(ci_io), .o_clock_out_pin_is_io(co_io),
        .o_resonator_on(reson), .o_driven_clock_in(drv), .o_clock_kind_field(kind),
        .o_osc_run(osc_run), .o_port_a_bit3_is_io(p3_io), .o_bandgap_trim_pair(bg),
        .o_data_protect(dprot), .o_code_protect(cprot),
        .o_undervoltage_guard_on(guard), .o_powerup_delay_on(dly),
        .o_watchdog_on(wdog), .o_core_reset(core_rst));

    // programmed bit reads 0, so enables and locks invert where noted
    function automatic logic [13:0] exp_dec(input logic [13:0] x);
        logic [2:0] k;
        k = x[2:0];
        return {x[13:12], ~x[8], ~x[7], x[6], ~x[4], x[3], k, k[2] & ~k[1],
            k == 3'h3 || k == 3'h4 || k == 3'h6, ~k[2] & ~(k[1] & k[0]), k == 3'h3};
    endfunction

    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rel(input int lim);
        n = 0;
        while (core_rst !== 1'b0 && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // whole run is well under a thousand cycles, far inside this 30000-cycle limit
    initial
    begin
        #3000000;
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        {rst, pin_n} = 2'h3;
        {brown, wake, trim_wr, b4_out, b4_oe, src_run} = 6'h00;
        trim_d = 8'h00;
        n_mismatch = 0;
        comparisons = 0;
        n = $urandom(55);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(dec, exp_dec(SETUP_RST));
        chk({6'h0, trim_reg}, {6'h0, TRIM_RST});
        partner_u.get(14'h2006, v);
        chk(v, 14'h0000);
        partner_u.get(SETUP_ADDR, v);
        chk(v, SETUP_RST);
        partner_u.leave();
        @(posedge clk);
        #1;
        chk(rdata, 14'h0000);
        $display("test reset and map done");
        for (int k = 0; k < 8; k++)
        begin
            w = 14'($urandom);
            w[2:0] = 3'(k);
            partner_u.put(SETUP_ADDR, w, 1'b1, 1'b0);
            partner_u.get(SETUP_ADDR, v);
            chk(v, w & ~UNIMPL_MASK);
            partner_u.leave();
            wait_rel(40);
            if (k < 3)
            begin
                chk({13'h0, core_rst}, 14'h0001);
                src_run <= 1'b1;
                wait_rel(100);
            end
            else
                chk({13'h0, n >= PW}, {13'h0, ~w[4]});
            chk({13'h0, core_rst}, 14'h0000);
            chk(dec, exp_dec(w));
            chk({13'h0, p3_io}, {13'h0, ~w[5]});
            for (int i = 0; i < 6; i++)
            begin
                v = 14'($urandom);
                @(posedge clk);
                b4_out <= v[0];
                b4_oe <= v[1];
                @(posedge clk);
                #1;
                if (k == 5 || k == 7)
                begin
                    if (i > 0)
                        chk({13'h0, co_o}, {13'h0, ~pv});
                    chk({13'h0, co_oe}, 14'h0001);
                end
                else if (k > 2)
                    chk({12'h0, co_oe, co_o}, {12'h0, v[1:0]});
                else
                    chk({13'h0, co_oe}, 14'h0000);
                pv = co_o;
            end
            src_run <= 1'b0;
            $display("test clock kind %0d done", k);
        end
        for (int j = 0; j < 2; j++)
        begin
            partner_u.put(SETUP_ADDR, j ? 14'h3fcc : 14'h3fec, 1'b1, 1'b0);
            partner_u.leave();
            wait_rel(40);
            @(posedge clk);
            pin_n <= 1'b0;
            repeat (4) @(posedge clk);
            #1;
            chk({12'h0, osc_run, core_rst}, j ? 14'h0002 : 14'h0001);
            @(posedge clk);
            pin_n <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            chk({12'h0, osc_run, core_rst}, 14'h0002);
        end
        $display("test reset pin done");
        // guard is on in the last word, so a brown-out restarts the delay
        brown <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({13'h0, core_rst}, 14'h0001);
        brown <= 1'b0;
        wait_rel(40);
        chk({13'h0, n >= PW}, 14'h0001);
        $display("test brown-out done");
        partner_u.put(SETUP_ADDR, 14'h3e7f, 1'b1, 1'b0);
        partner_u.get(TRIM_ADDR, v);
        chk(v, 14'h0000);
        partner_u.put(SETUP_ADDR, 14'h3fff, 1'b1, 1'b0);
        #1;
        chk({12'h0, e_data, e_prog}, 14'h0003);
        @(posedge clk);
        #1;
        chk({12'h0, e_data, e_prog}, 14'h0000);
        $display("test unlock erase done");
        w = RETURN_LITERAL_OP_OP | {6'h00, 8'($urandom)};
        partner_u.put(TRIM_ADDR, w, 1'b1, 1'b0);
        partner_u.put(SETUP_ADDR, 14'h1fff, 1'b1, 1'b0);
        partner_u.erase_keep();
        partner_u.leave();
        repeat (3) @(posedge clk);
        #1;
        chk({5'h0, lit_ok, lit}, {5'h0, 1'b1, w[7:0]});
        chk({12'h0, bg}, 14'h0001);
        @(posedge clk);
        trim_wr <= 1'b1;
        trim_d <= w[7:0] ^ 8'h5a;
        @(posedge clk);
        trim_wr <= 1'b0;
        #1;
        chk({6'h0, trim_reg}, {6'h0, w[7:0] ^ 8'h5a});
        $display("test trim done");
        wrap_up();
    end
endmodule
`default_nettype wire
